// ===== tcm_pkg.sv
// package: register map, field layout and codes of the 16-bit timer block
package tcm_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA  = 8'h0C;
  localparam logic [7:0] OFS_CMPB  = 8'h10;
  localparam logic [7:0] OFS_CAPT  = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_PORT  = 8'h1C;

  // ==========================================================
  // field positions
  localparam int CTRL_WMS_LSB  = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CS_LSB   = 8;
  localparam int FLG_OVF       = 0;
  localparam int FLG_CMPA      = 1;
  localparam int FLG_CMPB      = 2;
  localparam int FLG_CAP       = 3;
  localparam int PORT_DATA_LSB = 0;
  localparam int PORT_DIR_LSB  = 2;
  localparam int PORT_OST_LSB  = 4;

  // ==========================================================
  // values and codes
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [3:0]  WMS_NORMAL = 4'h0;
  localparam logic [3:0]  WMS_CLR_A  = 4'h4;
  localparam logic [3:0]  WMS_CLR_CAP = 4'hC;
  localparam logic [1:0]  COM_NONE   = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_CLEAR  = 2'h2;
  localparam logic [1:0]  COM_SET    = 2'h3;
  localparam logic [2:0]  CS_STOP    = 3'h0;
  localparam logic [2:0]  CS_DIV1    = 3'h1;
  localparam logic [2:0]  CS_DIV8    = 3'h2;
  localparam logic [2:0]  CS_DIV64   = 3'h3;
  localparam logic [2:0]  CS_DIV256  = 3'h4;
  localparam logic [2:0]  CS_DIV1024 = 3'h5;

  // interrupt service acknowledges from the interrupt controller
  typedef struct packed {
    logic cap;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tcm_ack_t;

  // compare output pins, bit 0 is channel A, bit 1 channel B
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } tcm_pin_t;

endpackage

// ===== tcm_timer.sv
// 16-bit timer: normal and clear-on-match counting, compare output unit
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module tcm_timer
#(
  parameter int PRESC_W = 10
)
(
  input  wire logic            i_clock,
  input  wire logic            i_rst,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic [31:0]          prdata,
  input  wire logic            i_capture_strobe,
  input  wire tcm_pkg::tcm_ack_t i_ack,
  output logic [3:0]           o_flags,
  output tcm_pkg::tcm_pin_t    o_pins
);
  import tcm_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic apply_com(input logic st, input logic [1:0] com);
    case (com)
      COM_TOGGLE: apply_com = ~st;
      COM_CLEAR:  apply_com = 1'b0;
      COM_SET:    apply_com = 1'b1;
      default:    apply_com = st;
    endcase
  endfunction

  function automatic logic is_hit(input logic [15:0] a,
                                  input logic [15:0] b);
    is_hit = (a == b);
  endfunction

  function automatic logic non_pwm(input logic [3:0] w);
    non_pwm = (w == WMS_NORMAL) || (w == WMS_CLR_A) || (w == WMS_CLR_CAP);
  endfunction

  // ==========================================================
  // registers
  logic [3:0]         wms_reg;
  logic [1:0]         com_a_reg, com_b_reg;
  logic [2:0]         cs_reg;
  logic [15:0]        cnt_reg, cmpa_reg, cmpb_reg, capt_reg;
  logic [3:0]         flags_reg;
  logic [1:0]         port_reg, dir_reg, ost_reg;
  logic               block_reg, pend_a_reg, pend_b_reg, pend_cap_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [31:0]        prdata_reg;

  // ==========================================================
  // apb decode
  logic        wr_en, setup, mapped;
  logic        wr_ctrl, wr_force, wr_cnt;
  logic [31:0] rd_mux;

  assign pready  = 1'b1;
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_FORCE) ||
                   (paddr == OFS_COUNT) || (paddr == OFS_CMPA) ||
                   (paddr == OFS_CMPB) || (paddr == OFS_CAPT) ||
                   (paddr == OFS_FLAGS) || (paddr == OFS_PORT);
  assign pslverr = psel && penable && !mapped;
  assign wr_ctrl  = wr_en && (paddr == OFS_CTRL);
  assign wr_force = wr_en && (paddr == OFS_FORCE);
  assign wr_cnt   = wr_en && (paddr == OFS_COUNT);
  assign prdata   = prdata_reg;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:
      begin
        rd_mux[CTRL_WMS_LSB +: 4]  = wms_reg;
        rd_mux[CTRL_COMA_LSB +: 2] = com_a_reg;
        rd_mux[CTRL_COMB_LSB +: 2] = com_b_reg;
        rd_mux[CTRL_CS_LSB +: 3]   = cs_reg;
      end
      OFS_COUNT: rd_mux[15:0] = cnt_reg;
      OFS_CMPA:  rd_mux[15:0] = cmpa_reg;
      OFS_CMPB:  rd_mux[15:0] = cmpb_reg;
      OFS_CAPT:  rd_mux[15:0] = capt_reg;
      OFS_FLAGS: rd_mux[3:0]  = flags_reg;
      OFS_PORT:
      begin
        rd_mux[PORT_DATA_LSB +: 2] = port_reg;
        rd_mux[PORT_DIR_LSB +: 2]  = dir_reg;
        rd_mux[PORT_OST_LSB +: 2]  = ost_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so it stands for the access
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      prdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_reg <= rd_mux;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wms_reg   <= WMS_NORMAL;
      com_a_reg <= COM_NONE;
      com_b_reg <= COM_NONE;
      cs_reg    <= CS_STOP;
    end
    else if (wr_ctrl)
    begin
      // mode bits are not buffered: they apply from the next clock on
      wms_reg   <= pwdata[CTRL_WMS_LSB +: 4];
      com_a_reg <= pwdata[CTRL_COMA_LSB +: 2];
      com_b_reg <= pwdata[CTRL_COMB_LSB +: 2];
      cs_reg    <= pwdata[CTRL_CS_LSB +: 3];
    end
  end

  // top registers load directly, no double buffer in these modes
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cmpa_reg <= CNT_BOTTOM;
      cmpb_reg <= CNT_BOTTOM;
    end
    else
    begin
      if (wr_en && (paddr == OFS_CMPA))
        cmpa_reg <= pwdata[15:0];
      if (wr_en && (paddr == OFS_CMPB))
        cmpb_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      port_reg <= 2'b00;
      dir_reg  <= 2'b00;
    end
    else if (wr_en && (paddr == OFS_PORT))
    begin
      port_reg <= pwdata[PORT_DATA_LSB +: 2];
      dir_reg  <= pwdata[PORT_DIR_LSB +: 2];
    end
  end

  // ==========================================================
  // prescaler
  logic tick;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      presc_reg <= '0;
    else
      presc_reg <= presc_reg + PRESC_W'(1);
  end

  always_comb
  begin
    case (cs_reg)
      CS_DIV1:    tick = 1'b1;
      CS_DIV8:    tick = &presc_reg[2:0];
      CS_DIV64:   tick = &presc_reg[5:0];
      CS_DIV256:  tick = &presc_reg[7:0];
      CS_DIV1024: tick = &presc_reg[9:0];
      default:    tick = 1'b0;
    endcase
  end

  // ==========================================================
  // compare and counter
  logic        is_clr, match_a, match_b, top_hit, wrap;
  logic [15:0] top_val;

  assign is_clr  = (wms_reg == WMS_CLR_A) || (wms_reg == WMS_CLR_CAP);
  assign top_val = (wms_reg == WMS_CLR_CAP) ? capt_reg : cmpa_reg;
  assign match_a = tick && !block_reg && is_hit(cnt_reg, cmpa_reg);
  assign match_b = tick && !block_reg && is_hit(cnt_reg, cmpb_reg);
  assign top_hit = is_clr && tick && !block_reg &&
                   is_hit(cnt_reg, top_val);
  assign wrap    = tick && !wr_cnt && (cnt_reg == CNT_MAX);

  // a counter write blocks matches until the next tick has passed
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      block_reg <= 1'b0;
    else if (wr_cnt)
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      cnt_reg <= CNT_BOTTOM;
    else if (wr_cnt)
      cnt_reg <= pwdata[15:0];
    else if (top_hit)
      cnt_reg <= CNT_BOTTOM;
    else if (tick)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // capture loads from the capture unit unless it is serving as top
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      capt_reg <= CNT_BOTTOM;
    else if (wr_en && (paddr == OFS_CAPT))
      capt_reg <= pwdata[15:0];
    else if (i_capture_strobe && (wms_reg != WMS_CLR_CAP))
      capt_reg <= cnt_reg;
  end

  // ==========================================================
  // flags: match flags arrive on the tick after the match
  logic [3:0] flag_set, flag_clr;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pend_a_reg   <= 1'b0;
      pend_b_reg   <= 1'b0;
      pend_cap_reg <= 1'b0;
    end
    else
    begin
      if (match_a)
        pend_a_reg <= 1'b1;
      else if (tick)
        pend_a_reg <= 1'b0;
      if (match_b)
        pend_b_reg <= 1'b1;
      else if (tick)
        pend_b_reg <= 1'b0;
      if (top_hit && (wms_reg == WMS_CLR_CAP))
        pend_cap_reg <= 1'b1;
      else if (tick)
        pend_cap_reg <= 1'b0;
    end
  end

  always_comb
  begin
    flag_set = 4'h0;
    flag_set[FLG_OVF]  = wrap;
    flag_set[FLG_CMPA] = tick && pend_a_reg;
    flag_set[FLG_CMPB] = tick && pend_b_reg;
    flag_set[FLG_CAP]  = (tick && pend_cap_reg) ||
                         (i_capture_strobe && (wms_reg != WMS_CLR_CAP));
    flag_clr = {i_ack.cap, i_ack.cmp_b, i_ack.cmp_a, i_ack.ovf};
    if (wr_en && (paddr == OFS_FLAGS))
      flag_clr = flag_clr | pwdata[3:0];
  end

  // set wins over clear so no event is lost
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      flags_reg <= 4'h0;
    else
      flags_reg <= flag_set | (flags_reg & ~flag_clr);
  end

  assign o_flags = flags_reg;

  // ==========================================================
  // compare output unit
  logic force_a, force_b;

  assign force_a = wr_force && pwdata[0] && non_pwm(wms_reg);
  assign force_b = wr_force && pwdata[1] && non_pwm(wms_reg);

  // state updates even while the pin is an input, ready for enabling
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      ost_reg <= 2'b00;
    else
    begin
      if (match_a || force_a)
        ost_reg[0] <= apply_com(ost_reg[0], com_a_reg);
      if (match_b || force_b)
        ost_reg[1] <= apply_com(ost_reg[1], com_b_reg);
    end
  end

  always_comb
  begin
    o_pins.out[0] = (com_a_reg != COM_NONE) ? ost_reg[0] : port_reg[0];
    o_pins.out[1] = (com_b_reg != COM_NONE) ? ost_reg[1] : port_reg[1];
    o_pins.oe     = dir_reg;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_match_a;
    match_a && !force_a;
  endsequence

  sequence s_flag_tick;
    pend_a_reg && tick;
  endsequence

  a_reset_state_zero: assert property ($past(i_rst) |-> ost_reg == '0)
    else $error("output state not zero after reset");

  a_pin_source_sel: assert property ((com_a_reg != COM_NONE) |->
      (o_pins.out[0] == ost_reg[0]) && (o_pins.oe[0] == dir_reg[0]))
    else $error("pin not driven from output state");

  a_mode_zero_hold: assert property (
      (match_a && com_a_reg == COM_NONE) |=> $stable(ost_reg[0]))
    else $error("mode zero changed output state");

  a_toggle_on_match: assert property ((s_match_a ##0
      (com_a_reg == COM_TOGGLE)) |=> ost_reg[0] != $past(ost_reg[0]))
    else $error("toggle mode did not toggle");

  a_normal_wrap_ovf: assert property ((tick && !wr_cnt &&
      wms_reg == WMS_NORMAL && cnt_reg == CNT_MAX)
      |=> cnt_reg == CNT_BOTTOM && flags_reg[FLG_OVF])
    else $error("normal mode wrap or overflow flag wrong");

  a_top_clear_count: assert property ((top_hit && !wr_cnt)
      |=> cnt_reg == CNT_BOTTOM)
    else $error("counter not cleared at top");

  a_flag_delay_a: assert property (s_match_a |=> pend_a_reg ##0
      (!flags_reg[FLG_CMPA] || $past(flags_reg[FLG_CMPA]) ||
       $past(pend_a_reg)))
    else $error("compare flag set in the match tick");

  a_flag_tick: assert property (s_flag_tick |=> flags_reg[FLG_CMPA])
    else $error("compare flag missing after tick");

  a_write_blocks: assert property (wr_cnt |=> !match_a && !match_b)
    else $error("match not blocked after counter write");

  a_force_no_count: assert property (
      (force_a && !tick && !wr_cnt && !pend_a_reg)
      |=> $stable(cnt_reg) && !pend_a_reg)
    else $error("force strobe disturbed counter");

endmodule

`default_nettype wire

// ===== tcm_pin_model.sv
// partner model: load on the compare output pins, with a weak pull-up
`timescale 1ns/1ns
`default_nettype none

module tcm_pin_model
(
  input  wire logic              i_clock,
  input  wire tcm_pkg::tcm_pin_t i_pins,
  output logic [1:0]             o_line,
  output logic [15:0]            o_half_a
);
  import tcm_pkg::*;

  logic [15:0] run_cnt = 16'h0000;
  logic        last_a  = 1'b1;

  // ==========================================================
  // wire level
  // an input pin floats up to the pull-up, never to the last driven value
  always_comb
  begin
    o_line[0] = i_pins.oe[0] ? i_pins.out[0] : 1'b1;
    o_line[1] = i_pins.oe[1] ? i_pins.out[1] : 1'b1;
  end

  // ==========================================================
  // half period of channel A, in clocks between two level changes
  always_ff @(posedge i_clock)
  begin
    last_a <= o_line[0];
    if (o_line[0] != last_a)
    begin
      o_half_a <= run_cnt;
      run_cnt  <= 16'h0001;
    end
    else
      run_cnt <= run_cnt + 16'h0001;
  end

endmodule

`default_nettype wire

// ===== timer16_compare_output_normal_ctc_tb.sv
// testbench for the 16-bit timer with compare output unit
`timescale 1ns/1ns
`default_nettype none

module timer16_compare_output_normal_ctc_tb;
  import tcm_pkg::*;

  logic        i_clock, i_rst, psel, penable, pwrite, i_cap, err;
  logic        pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  flags;
  logic [1:0]  line;
  logic [15:0] half_a;
  tcm_ack_t    ack;
  tcm_pin_t    pins;
  int          miscompares, tests_run;

  tcm_timer #(.PRESC_W(10)) u_tcm_timer (
    .i_clock(i_clock), .i_rst(i_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .i_capture_strobe(i_cap),
    .i_ack(ack), .o_flags(flags), .o_pins(pins));

  tcm_pin_model u_tcm_pin_model (
    .i_clock(i_clock), .i_pins(pins), .o_line(line), .o_half_a(half_a));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1)
      @(posedge i_clock);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs are looked at mid-cycle, after every edge update has landed
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic pulse(input logic [3:0] a, input logic c);
    @(posedge i_clock);
    ack   <= a;
    i_cap <= c;
    @(posedge i_clock);
    ack   <= 4'h0;
    i_cap <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] w,
                                      input logic [1:0] c,
                                      input logic [2:0] s);
    return {21'h0, s, 2'h0, c, w};
  endfunction

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    settle(0);
    check(pins, 4'h0);
    bus(1'b1, OFS_PORT, 32'h30);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    bus(1'b1, 8'h24, 32'h1);
    check(err, 1'b1);
  endtask

  task automatic t_force;
    logic [1:0] code [3] = '{COM_CLEAR, COM_TOGGLE, COM_SET};
    logic       lv [3]   = '{1'b0, 1'b1, 1'b1};
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_SET, CS_STOP));
    bus(1'b1, OFS_FORCE, 32'h1);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd[5:2], 4'h4);
    bus(1'b1, OFS_PORT, 32'h4);
    settle(0);
    check({pins.oe[0], line[0]}, 2'b11);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, code[i], CS_STOP));
      bus(1'b1, OFS_FORCE, 32'h1);
      settle(0);
      check(line[0], lv[i]);
    end
    bus(1'b0, OFS_FLAGS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_NONE, CS_STOP));
    bus(1'b1, OFS_FORCE, 32'h1);
    settle(0);
    check(line[0], 1'b0);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd[4], 1'b1);
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_NONE, CS_STOP) | 32'hC0);
    bus(1'b1, OFS_FORCE, 32'h2);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd[5:4], 2'b11);
  endtask

  task automatic t_normal;
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_NONE, CS_DIV1));
    bus(1'b1, OFS_COUNT, 32'hFFFD);
    settle(8);
    check(flags[FLG_OVF], 1'b1);
    settle(20);
    check(flags[FLG_OVF], 1'b1);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(rd[15:0] < 16'h0040, 1'b1);
    pulse(4'h1, 1'b0);
    settle(0);
    check(flags[FLG_OVF], 1'b0);
  endtask

  task automatic t_toggle;
    int p [5] = '{1, 8, 64, 256, 1024};
    bus(1'b1, OFS_FLAGS, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, OFS_CTRL, ctl(WMS_CLR_A, COM_TOGGLE, CS_STOP));
      // the count write blocks the first tick, so it must not land on top
      bus(1'b1, OFS_COUNT, 32'hFFFF);
      bus(1'b1, OFS_CMPA, 32'(i % 2));
      bus(1'b1, OFS_CTRL, ctl(WMS_CLR_A, COM_TOGGLE, CS_DIV1 + 3'(i)));
      settle(3 * p[i] * (i % 2 + 1) + 8);
      check(half_a, 16'(p[i] * (i % 2 + 1)));
    end
    check(flags[FLG_CMPA], 1'b1);
  endtask

  task automatic t_top_wrap;
    bus(1'b1, OFS_CTRL, ctl(WMS_CLR_A, COM_NONE, CS_STOP));
    bus(1'b1, OFS_FLAGS, 32'hF);
    bus(1'b0, OFS_FLAGS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, OFS_CMPA, 32'h5);
    bus(1'b1, OFS_COUNT, 32'hFFF0);
    bus(1'b1, OFS_CTRL, ctl(WMS_CLR_A, COM_NONE, CS_DIV1));
    settle(40);
    check(flags[FLG_OVF], 1'b1);
    check(flags[FLG_CMPA], 1'b1);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(rd[15:0] <= 16'h0005, 1'b1);
  endtask

  task automatic t_block;
    // move top away first so no match is left pending when the timer stops
    bus(1'b1, OFS_CMPA, 32'h100);
    settle(8);
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_SET, CS_STOP));
    bus(1'b1, OFS_FORCE, 32'h1);
    bus(1'b1, OFS_COUNT, 32'h100);
    bus(1'b1, OFS_FLAGS, 32'hF);
    bus(1'b1, OFS_CTRL, ctl(WMS_NORMAL, COM_TOGGLE, CS_DIV1));
    pulse(4'h0, 1'b1);
    settle(10);
    check(flags, 4'h8);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd[4], 1'b1);
  endtask

  task automatic t_capture_top;
    bus(1'b1, OFS_CTRL, ctl(WMS_CLR_CAP, COM_TOGGLE, CS_STOP));
    bus(1'b1, OFS_CAPT, 32'h2);
    bus(1'b1, OFS_CMPA, 32'h2);
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'hF);
    bus(1'b1, OFS_CTRL, ctl(WMS_CLR_CAP, COM_TOGGLE, CS_DIV1));
    pulse(4'h0, 1'b1);
    settle(20);
    check(half_a, 16'h0003);
    check(flags[FLG_CAP], 1'b1);
    bus(1'b0, OFS_CAPT, 32'h0);
    check(rd, 32'h2);
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // longest path is the slow prescaler sweep, a few thousand cycles
  initial
  begin
    repeat (50000) @(posedge i_clock);
    miscompares++;
    end_sim();
  end

  initial
  begin
    i_rst       = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    i_cap       = 1'b0;
    ack         = 4'h0;
    miscompares = 0;
    tests_run   = 0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_force();
    t_normal();
    t_toggle();
    t_top_wrap();
    t_block();
    t_capture_top();
    end_sim();
  end

endmodule

`default_nettype wire
